// ==== rtl/pss_pkg.sv ====
// Purpose: constants and types of the status summary block
// Assumes: command codes arrive over the two-wire management bus
// Notes: masks sit at command codes 0x60 above the status bytes
package pss_pkg;
    // Command codes
    localparam logic [7:0] CMD_FALL    = 8'h65;
    localparam logic [7:0] CMD_SBYTE   = 8'h78;
    localparam logic [7:0] CMD_SWORD   = 8'h79;
    localparam logic [7:0] CMD_PG_MASK = 8'hD9;
    localparam int         NSTAT       = 6;
    localparam int         IX_VOUT     = 0;
    localparam int         IX_IOUT     = 1;
    localparam int         IX_INPUT    = 2;
    localparam int         IX_TEMP     = 3;
    localparam int         IX_CML      = 4;
    localparam int         IX_MFR      = 5;
    localparam logic [7:0] STAT_CMD  [NSTAT] = '{8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80};
    localparam logic [7:0] MASK_CMD  [NSTAT] = '{8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hE0};
    localparam logic [7:0] STAT_WBIT [NSTAT] = '{8'hFC, 8'hA0, 8'h08, 8'hC0, 8'hF2, 8'h82};
    // Values after reset
    localparam logic [7:0] STAT_RST  [NSTAT] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MASK_RST        = 8'h00;
    localparam logic       PG_MASK_RST     = 1'b1;
    localparam logic [6:0] FALL_RST        = 7'h00;
    localparam int         PG_BIT          = 3;
    // Fall time buckets: upper bound and time in ms
    localparam int         FALL_N = 14;
    localparam logic [6:0] FALL_BOUND [FALL_N] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06,
        7'h09, 7'h0C, 7'h11, 7'h16, 7'h20, 7'h2C, 7'h3E, 7'h56};
    localparam logic [6:0] FALL_TIME  [FALL_N] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06,
        7'h07, 7'h0A, 7'h0E, 7'h13, 7'h1B, 7'h25, 7'h34, 7'h48};
    localparam logic [6:0] FALL_MAX_MS = 7'h64;
    localparam logic [6:0] FALL_TOP    = 7'h56;

    // Detailed condition levels from the converter
    typedef struct packed {
        logic ov_fault;
        logic ov_warn;
        logic uv_warn;
        logic uv_fault;
        logic vmax_warn;
        logic turn_on_timeout;
        logic oc_fault;
        logic oc_warn;
        logic vin_above_on;
        logic vin_below_off;
        logic ot_fault;
        logic ot_warn;
        logic pec_err;
        logic mem_err;
        logic oth_err;
        logic int_ot;
        logic vmin_warn;
    } pss_cond_s;

    // Serial slave states
    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_ADDR     = 7'h02,
        ST_ACK_ADDR = 7'h04,
        ST_WR       = 7'h08,
        ST_ACK_WR   = 7'h10,
        ST_RD       = 7'h20,
        ST_ACK_RD   = 7'h40
    } pss_state_e;

    // Mantissa to effective fall time
    function automatic logic [6:0] pss_fall_ms(input logic [6:0] m);
        logic [6:0] r;
        r = FALL_MAX_MS;
        for (int k = FALL_N - 1; k >= 0; k--) begin
            if (m <= FALL_BOUND[k]) r = FALL_TIME[k];
        end
        return r;
    endfunction : pss_fall_ms

    // Command known to this block
    function automatic logic pss_cmd_ok(input logic [7:0] c);
        logic ok;
        ok = (c == CMD_FALL) || (c == CMD_SBYTE) || (c == CMD_SWORD) || (c == CMD_PG_MASK);
        for (int k = 0; k < NSTAT; k++) begin
            if (c == STAT_CMD[k] || c == MASK_CMD[k]) ok = 1'b1;
        end
        return ok;
    endfunction : pss_cmd_ok
endpackage : pss_pkg

// ==== rtl/pss_w1c_reg.sv ====
// Purpose: sticky status bits, set by hardware, cleared by writing one
// Assumes: clear is a single-cycle strobe on core_clk; set follows condition levels
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module pss_w1c_reg #(
    parameter int               WIDTH   = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Set and clear strobes
    input  wire logic [WIDTH-1:0] set_v,
    input  wire logic [WIDTH-1:0] clr_v,
    // Held bits
    output logic      [WIDTH-1:0] bits_q
);
    // Set wins over clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bits_q <= RST_VAL;
        end else begin
            bits_q <= (bits_q & ~clr_v) | set_v;
        end
    end

    set_wins_a : assert property (@(posedge core_clk) disable iff (!rst_n)
        (set_v & clr_v) != '0 |=> (bits_q & $past(set_v & clr_v)) == $past(set_v & clr_v))
        else $error("clear beat a simultaneous set");
endmodule : pss_w1c_reg
`default_nettype wire

// ==== rtl/pss_top.sv ====
// Purpose: status summary, voltage status and fall time over the serial bus
// Assumes: condition inputs come from logic on core_clk
// Notes: SCL and SDA are pins and pass a three-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
module pss_top #(
    parameter logic [6:0] SLAVE_ADDR = 7'h10
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Serial bus pins
    input  wire logic              smb_scl,
    input  wire logic              smb_sda_in,
    output logic                   smb_sda_out,
    output logic                   smb_sda_oe,
    output logic                   smb_alert_n,
    // Converter state
    input  wire pss_pkg::pss_cond_s cond,
    input  wire logic              conv_enable,
    // Effective soft-stop fall time in ms
    output logic            [6:0]  fall_ms
);
    import pss_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    //----------------------------------------
    // Pin synchronisers and filtering
    //----------------------------------------
    logic [2:0] scl_s_q;
    logic [2:0] sda_s_q;
    logic       scl_f_q;
    logic       sda_f_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;

    // Three stages per pin
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
        end else begin
            scl_s_q <= {scl_s_q[1:0], smb_scl};
            sda_s_q <= {sda_s_q[1:0], smb_sda_in};
        end
    end

    // Level taken once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else begin
            if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
            if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
        end
    end

    // Edges and bus conditions
    always_comb begin
        scl_rise  = (scl_s_q[1] == scl_s_q[2]) && scl_s_q[2] && !scl_f_q;
        scl_fall  = (scl_s_q[1] == scl_s_q[2]) && !scl_s_q[2] && scl_f_q;
        bus_start = (sda_s_q[1] == sda_s_q[2]) && !sda_s_q[2] && sda_f_q && scl_f_q;
        bus_stop  = (sda_s_q[1] == sda_s_q[2]) && sda_s_q[2] && !sda_f_q && scl_f_q;
    end

    //----------------------------------------
    // Serial slave
    //----------------------------------------
    pss_state_e state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic       rw_q;
    logic       nack_q;
    logic       sda_oe_q;
    logic [1:0] rd_idx_q;
    logic [7:0] rd_byte;
    logic       byte_done;

    assign byte_done = (state_q == ST_WR) && scl_fall && (bit_cnt_q == 4'h8)
                       && !bus_start && !bus_stop;

    // Byte framing, acknowledge and read shifting
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            rx_q      <= 8'h00;
            tx_q      <= 8'hFF;
            rw_q      <= 1'b0;
            nack_q    <= 1'b0;
            sda_oe_q  <= 1'b0;
            rd_idx_q  <= 2'h0;
        end else if (bus_start) begin
            state_q   <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_q  <= 1'b0;
            rd_idx_q  <= 2'h0;
        end else if (bus_stop) begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        rx_q      <= {rx_q[6:0], sda_f_q};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        if (state_q == ST_WR) begin
                            sda_oe_q <= 1'b1;
                            state_q  <= ST_ACK_WR;
                        end else if (rx_q[7:1] == SLAVE_ADDR) begin
                            rw_q     <= rx_q[0];
                            sda_oe_q <= 1'b1;
                            state_q  <= ST_ACK_ADDR;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_ACK_ADDR, ST_ACK_WR: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == ST_ACK_ADDR && rw_q) begin
                            tx_q     <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                            rd_idx_q <= 2'h1;
                            state_q  <= ST_RD;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_WR;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        sda_oe_q <= 1'b0;
                        state_q  <= ST_ACK_RD;
                    end else if (scl_fall && bit_cnt_q != 4'h0) begin
                        tx_q     <= {tx_q[6:0], 1'b1};
                        sda_oe_q <= ~tx_q[6];
                    end
                end
                ST_ACK_RD: begin
                    if (scl_rise) begin
                        nack_q <= sda_f_q;
                    end else if (scl_fall && nack_q) begin
                        state_q <= ST_IDLE;
                    end else if (scl_fall) begin
                        tx_q      <= rd_byte;
                        sda_oe_q  <= ~rd_byte[7];
                        bit_cnt_q <= 4'h0;
                        if (rd_idx_q != 2'h3) rd_idx_q <= rd_idx_q + 2'h1;
                        state_q   <= ST_RD;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    //----------------------------------------
    // Write capture and decode
    //----------------------------------------
    logic [7:0]  cmd_q;
    logic [15:0] data_q;
    logic [2:0]  nbytes_q;
    logic        wr_pend_q;
    logic        commit;
    logic        wr_byte_ok;
    logic        wr_word_ok;
    logic        ivc_evt;
    logic        ivd_evt;

    // Command then data bytes, low byte first
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmd_q     <= 8'h00;
            data_q    <= 16'h0000;
            nbytes_q  <= 3'h0;
            wr_pend_q <= 1'b0;
        end else if (bus_start || bus_stop) begin
            nbytes_q  <= 3'h0;
            wr_pend_q <= 1'b0;
        end else if (byte_done) begin
            if (nbytes_q == 3'h0) cmd_q <= rx_q;
            else if (nbytes_q == 3'h1) data_q[7:0] <= rx_q;
            else data_q[15:8] <= rx_q;
            if (nbytes_q != 3'h7) nbytes_q <= nbytes_q + 3'h1;
            if (nbytes_q != 3'h0) wr_pend_q <= 1'b1;
        end
    end

    // Writes act when the frame ends
    always_comb begin
        commit     = (bus_start || bus_stop) && wr_pend_q;
        wr_byte_ok = commit && (nbytes_q == 3'h2) && (cmd_q != CMD_FALL);
        wr_word_ok = commit && (nbytes_q == 3'h3) && (cmd_q == CMD_FALL)
                     && (data_q[15:7] == 9'h000);
        ivc_evt    = byte_done && (nbytes_q == 3'h0) && !pss_cmd_ok(rx_q);
        ivd_evt    = commit && pss_cmd_ok(cmd_q) && !wr_byte_ok && !wr_word_ok
                     && (cmd_q != CMD_SBYTE) && (cmd_q != CMD_SWORD);
    end

    //----------------------------------------
    // Detailed status bytes
    //----------------------------------------
    logic [7:0] set_v  [NSTAT];
    logic [7:0] clr_v  [NSTAT];
    logic [7:0] stat_q [NSTAT];
    logic       vin_seen_q;

    // Input seen above turn-on once
    always_ff @(posedge core_clk) begin
        if (!rst_n) vin_seen_q <= 1'b0;
        else if (cond.vin_above_on) vin_seen_q <= 1'b1;
    end

    // Hardware set sources per byte
    always_comb begin
        set_v[IX_VOUT]  = {cond.ov_fault, cond.ov_warn, cond.uv_warn, cond.uv_fault,
                           cond.vmax_warn, cond.turn_on_timeout, 2'b00};
        set_v[IX_IOUT]  = {cond.oc_fault, 1'b0, cond.oc_warn, 5'h00};
        set_v[IX_INPUT] = {4'h0, vin_seen_q && cond.vin_below_off, 3'h0};
        set_v[IX_TEMP]  = {cond.ot_fault, cond.ot_warn, 6'h00};
        set_v[IX_CML]   = {ivc_evt, ivd_evt, cond.pec_err, cond.mem_err, 2'b00,
                           cond.oth_err, 1'b0};
        set_v[IX_MFR]   = {cond.int_ot, 5'h00, cond.vmin_warn, 1'b0};
        for (int i = 0; i < NSTAT; i++) begin
            clr_v[i] = (wr_byte_ok && cmd_q == STAT_CMD[i]) ? (data_q[7:0] & STAT_WBIT[i]) : 8'h00;
        end
        if (!vin_seen_q && cond.vin_above_on) clr_v[IX_INPUT][3] = 1'b1;
    end

    // One sticky byte per status register
    for (genvar g = 0; g < NSTAT; g++) begin : g_stat
        pss_w1c_reg #(
            .WIDTH   (8),
            .RST_VAL (STAT_RST[g])
        ) u_stat (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .set_v    (set_v[g]),
            .clr_v    (clr_v[g]),
            .bits_q   (stat_q[g])
        );
    end

    //----------------------------------------
    // Alert masks and fall time setting
    //----------------------------------------
    logic [7:0] mask_q [NSTAT];
    logic       pg_mask_q;
    logic [6:0] fall_m_q;
    logic [6:0] fall_ms_q;

    // Mask bytes written at their own codes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NSTAT; i++) mask_q[i] <= MASK_RST;
            pg_mask_q <= PG_MASK_RST;
        end else begin
            for (int i = 0; i < NSTAT; i++) begin
                if (wr_byte_ok && cmd_q == MASK_CMD[i]) mask_q[i] <= data_q[7:0] & STAT_WBIT[i];
            end
            if (wr_byte_ok && cmd_q == CMD_PG_MASK) pg_mask_q <= data_q[PG_BIT];
        end
    end

    // Fall mantissa and its bucketed time
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fall_m_q  <= FALL_RST;
            fall_ms_q <= pss_fall_ms(FALL_RST);
        end else begin
            if (wr_word_ok) fall_m_q <= data_q[6:0];
            fall_ms_q <= pss_fall_ms(fall_m_q);
        end
    end

    //----------------------------------------
    // Summaries, read data and alert
    //----------------------------------------
    logic [7:0] sbyte;
    logic [7:0] sword_hi;
    logic       pg_n;
    logic       alert_act;
    logic       alert_n_q;

    // Summary byte and status word high byte
    always_comb begin
        pg_n = cond.ov_fault || cond.ov_warn || cond.uv_warn || cond.uv_fault
               || cond.turn_on_timeout || cond.ot_fault || cond.ot_warn || cond.oc_fault
               || cond.oc_warn || !vin_seen_q || cond.vin_below_off;
        sbyte = {1'b0,
                 !conv_enable,
                 stat_q[IX_VOUT][7],
                 stat_q[IX_IOUT][7],
                 1'b0,
                 |stat_q[IX_TEMP][7:6],
                 |(stat_q[IX_CML] & STAT_WBIT[IX_CML]),
                 (|stat_q[IX_VOUT][6:2]) || stat_q[IX_IOUT][5] || stat_q[IX_INPUT][3]};
        sword_hi = {|stat_q[IX_VOUT][7:2],
                    stat_q[IX_IOUT][7] || stat_q[IX_IOUT][5],
                    |stat_q[IX_INPUT],
                    |stat_q[IX_MFR],
                    pg_n, 3'h0};
    end

    // Read data by command and byte index
    always_comb begin
        rd_byte = 8'hFF;
        case (cmd_q)
            CMD_SBYTE:   rd_byte = sbyte;
            CMD_SWORD:   rd_byte = (rd_idx_q == 2'h0) ? sbyte : sword_hi;
            CMD_FALL:    rd_byte = (rd_idx_q == 2'h0) ? {1'b0, fall_m_q} : 8'h00;
            CMD_PG_MASK: rd_byte = {4'h0, pg_mask_q, 3'h0};
            default: begin
                for (int i = 0; i < NSTAT; i++) begin
                    if (cmd_q == STAT_CMD[i]) rd_byte = stat_q[i] & STAT_WBIT[i];
                    if (cmd_q == MASK_CMD[i]) rd_byte = mask_q[i];
                end
            end
        endcase
    end

    // Any unmasked detailed bit asserts the alert, except input bit 3 alone before the input is first seen above turn-on
    always_comb begin
        alert_act = pg_n && !pg_mask_q;
        for (int i = 0; i < NSTAT; i++) begin
            if ((stat_q[i] & ~mask_q[i] & STAT_WBIT[i]) != 8'h00) alert_act = 1'b1;
        end
        if (!vin_seen_q && (stat_q[IX_INPUT] & ~mask_q[IX_INPUT] & ~STAT_WBIT[IX_INPUT]) == 8'h00
            && stat_q[IX_VOUT] == 8'h00 && stat_q[IX_IOUT] == 8'h00 && stat_q[IX_TEMP] == 8'h00
            && stat_q[IX_CML] == 8'h00 && stat_q[IX_MFR] == 8'h00 && !(pg_n && !pg_mask_q))
            alert_act = 1'b0;
    end

    // Registered pin and alert drivers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alert_n_q    <= 1'b1;
        end else begin
            alert_n_q    <= !alert_act;
        end
    end

    assign smb_sda_out = 1'b0;
    assign smb_sda_oe  = sda_oe_q;
    assign smb_alert_n = alert_n_q;
    assign fall_ms     = fall_ms_q;

    //----------------------------------------
    // Checks
    //----------------------------------------
    fall_upper_a : assert property (commit && cmd_q == CMD_FALL && data_q[15:7] != 9'h000 |=> $stable(fall_m_q))
        else $error("fall mantissa with upper bits set was taken");
    word_low_a : assert property (state_q == ST_ACK_ADDR && scl_fall && rw_q && cmd_q == CMD_SWORD
        |=> tx_q == $past(sbyte))
        else $error("status word low byte differs from summary byte");
    fall_top_a : assert property (fall_m_q > FALL_TOP |=> fall_ms_q == FALL_MAX_MS)
        else $error("fall time above top bucket not 100 ms");
    fall_low_a : assert property (fall_m_q <= 7'h01 |=> fall_ms_q == 7'h01)
        else $error("fastest fall time not 1 ms");
    byte_zero_a : assert property (sbyte[7] == 1'b0 && sbyte[3] == 1'b0)
        else $error("reserved summary bits set");
    off_bit_a : assert property (!conv_enable |-> sbyte[6])
        else $error("not-supplying bit clear while disabled");
    ov_mirror_a : assert property (cond.ov_fault |=> sbyte[5] && sword_hi[7])
        else $error("overvoltage fault missing from summaries");
    oc_mirror_a : assert property (cond.oc_fault |=> sbyte[4] ##0 sword_hi[6])
        else $error("overcurrent fault missing from summaries");
    sum_hold_a : assert property ($fell(sbyte[5]) |-> $past(clr_v[IX_VOUT][7]))
        else $error("summary bit cleared without its source");
    alert_on_a : assert property (alert_act |=> !smb_alert_n)
        else $error("alert not asserted for unmasked bit");
    pg_mask_a : assert property ($rose(rst_n) |-> pg_mask_q)
        else $error("power-not-good mask not set after reset");
endmodule : pss_top
`default_nettype wire

// ==== dv/pss_host.sv ====
// Purpose: management bus host driving the block's pins
// Assumes: SDA has a pull-up; 8 core cycles per bit phase
// Notes: nak flags any byte the device failed to acknowledge
`timescale 1ns/1ps
`default_nettype none
module pss_host #(
    parameter logic [6:0] ADDR = 7'h10
) (
    // Clock
    input  wire logic core_clk,
    // Bus pins
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    logic nak = 1'b0;
    // Idle bus, both lines released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Eight core cycles
    task automatic wt();
        repeat (8) @(posedge core_clk);
    endtask : wt
    // One bit of 160 ns, data changed mid-way through SCL low
    task automatic bitx(input logic b, output logic r);
        sda_pull <= ~b;
        repeat (4) @(posedge core_clk);
        scl <= 1'b1;
        wt();
        r = sda;
        scl <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : bitx
    // Start or repeated start
    task automatic start();
        sda_pull <= 1'b0;
        wt();
        scl <= 1'b1;
        wt();
        sda_pull <= 1'b1;
        wt();
        scl <= 1'b0;
        wt();
    endtask : start
    // Stop, bus left released
    task automatic stop();
        sda_pull <= 1'b1;
        wt();
        scl <= 1'b1;
        wt();
        sda_pull <= 1'b0;
        wt();
    endtask : stop
    // Byte out, ack sampled from the device
    task automatic byte_w(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        if (r !== 1'b0) begin
            nak = 1'b1;
        end
    endtask : byte_w
    // Byte in, then ack or nack on the last
    task automatic byte_r(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(last, r);
    endtask : byte_r
    // Write one or two bytes, low byte first
    task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d);
        start();
        byte_w({ADDR, 1'b0});
        byte_w(cmd);
        byte_w(d[7:0]);
        if (n == 2) begin
            byte_w(d[15:8]);
        end
        stop();
    endtask : wr
    // Read one or two bytes after a repeated start
    task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] d);
        d = 16'h0000;
        start();
        byte_w({ADDR, 1'b0});
        byte_w(cmd);
        start();
        byte_w({ADDR, 1'b1});
        byte_r(n == 1, d[7:0]);
        if (n == 2) begin
            byte_r(1'b1, d[15:8]);
        end
        stop();
    endtask : rd
endmodule : pss_host
`default_nettype wire

// ==== dv/pmbus_status_summary_tb_top.sv ====
// Purpose: self-checking bench for the status summary block
// Assumes: host model owns the bus pins
// Notes: hit pulses conditions one cycle, sticky bits hold them; mask_pg holds its condition
`timescale 1ns/1ps
`default_nettype none
module pmbus_status_summary_tb_top;
    import pss_pkg::*;
    localparam logic [16:0] BASE = 17'h00100;
    localparam logic [6:0] MANT [9] = '{7'h00, 7'h01, 7'h06, 7'h07, 7'h09, 7'h0A, 7'h56, 7'h57, 7'h7F};
    localparam logic [6:0] MS [9] = '{7'h01, 7'h01, 7'h06, 7'h07, 7'h07, 7'h0A, 7'h48, 7'h64, 7'h64};
    logic core_clk, rst_n, scl, sda_pull, sda_oe, sda_out, alert_n, conv_enable;
    logic [6:0] fall_ms;
    logic [15:0] r;
    pss_cond_s cond;
    wire logic sda;
    int fails = 0;
    int n_checks = 0;
    // Open-drain wire with pull-up
    assign sda = ~(sda_pull | (sda_oe & ~sda_out));
    pss_top #(.SLAVE_ADDR(7'h10)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .smb_scl(scl),
        .smb_sda_in(sda), .smb_sda_out(sda_out), .smb_sda_oe(sda_oe), .smb_alert_n(alert_n),
        .cond(cond), .conv_enable(conv_enable), .fall_ms(fall_ms));
    pss_host #(.ADDR(7'h10)) host_u (.core_clk(core_clk), .scl(scl), .sda_pull(sda_pull), .sda(sda));
    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // Compare and verdict
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    // Values straight out of reset
    task automatic reset_vals();
        host_u.rd(CMD_SBYTE, 1, r);
        chk(r, 16'h0041);
        host_u.rd(CMD_SWORD, 2, r);
        chk(r, 16'h2841);
        host_u.rd(STAT_CMD[IX_VOUT], 1, r);
        chk(r, 16'h0000);
        chk({15'h0000, alert_n}, 16'h0001);
        chk({9'h000, fall_ms}, 16'h0001);
    endtask : reset_vals
    // Bucket edges of the fall time, then an illegal mantissa
    task automatic fall_tab();
        for (int k = 0; k < 9; k++) begin
            host_u.wr(CMD_FALL, 2, {9'h000, MANT[k]});
            chk({9'h000, fall_ms}, {9'h000, MS[k]});
        end
        host_u.wr(CMD_FALL, 2, 16'h0080);
        chk({9'h000, fall_ms}, 16'h0064);
        host_u.rd(STAT_CMD[IX_CML], 1, r);
        chk(r, 16'h0040);
    endtask : fall_tab
    // Pulse one condition, check summaries and alert, then write-clear
    task automatic hit(input int b, input logic [15:0] exp, input logic [7:0] clr);
        @(posedge core_clk);
        cond <= pss_cond_s'(BASE | (17'h00001 << b));
        @(posedge core_clk);
        cond <= pss_cond_s'(BASE);
        host_u.wr(CMD_SBYTE, 1, 16'h00FF);
        host_u.rd(CMD_SWORD, 2, r);
        chk(r, exp);
        chk({15'h0000, alert_n}, 16'h0000);
        host_u.wr(clr, 1, 16'h00FF);
        host_u.rd(CMD_SWORD, 2, r);
        chk(r, 16'h0000);
        chk({15'h0000, alert_n}, 16'h0001);
    endtask : hit
    // Masked temperature warning, then power-not-good alert unmasked
    task automatic mask_pg();
        @(posedge core_clk);
        cond <= pss_cond_s'(BASE | 17'h00020);
        host_u.wr(MASK_CMD[IX_TEMP], 1, 16'h00FF);
        chk({15'h0000, alert_n}, 16'h0001);
        host_u.wr(CMD_PG_MASK, 1, 16'h0000);
        chk({15'h0000, alert_n}, 16'h0000);
        host_u.rd(CMD_SWORD, 2, r);
        chk(r, 16'h0804);
        @(posedge core_clk);
        cond <= pss_cond_s'(BASE);
        host_u.wr(STAT_CMD[IX_TEMP], 1, 16'h00FF);
        host_u.rd(CMD_SWORD, 2, r);
        chk(r, 16'h0000);
        chk({15'h0000, alert_n}, 16'h0001);
    endtask : mask_pg
    // Main sequence
    initial begin
        rst_n = 1'b0;
        conv_enable = 1'b0;
        cond = pss_cond_s'(17'h00000);
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        reset_vals();
        fall_tab();
        conv_enable <= 1'b1;
        cond <= pss_cond_s'(BASE);
        host_u.wr(STAT_CMD[IX_CML], 1, 16'h00FF);
        host_u.rd(CMD_SWORD, 2, r);
        chk(r, 16'h0000);
        hit(16, 16'h8020, STAT_CMD[IX_VOUT]);
        hit(13, 16'h8001, STAT_CMD[IX_VOUT]);
        hit(10, 16'h4010, STAT_CMD[IX_IOUT]);
        hit(9, 16'h4001, STAT_CMD[IX_IOUT]);
        hit(7, 16'h2001, STAT_CMD[IX_INPUT]);
        hit(5, 16'h0004, STAT_CMD[IX_TEMP]);
        hit(4, 16'h0002, STAT_CMD[IX_CML]);
        hit(1, 16'h1000, STAT_CMD[IX_MFR]);
        mask_pg();
        chk({15'h0000, host_u.nak}, 16'h0000);
        print_verdict();
    end
    // Hang guard
    initial begin
        repeat (90000) @(posedge core_clk);
        fails++;
        print_verdict();
    end
endmodule : pmbus_status_summary_tb_top
`default_nettype wire
